// ==== hw/iov_pkg.sv ====
// Constants, field layouts and conversions for the input overvoltage fault block
package iov_pkg;

	// ------------------------------------------------------------
	// Command codes
	// ------------------------------------------------------------
	localparam logic [7:0] IOV_CMD_LIMIT = 8'h55; // Limit, word access
	localparam logic [7:0] IOV_CMD_RESP = 8'h56; // Response, byte access

	// ------------------------------------------------------------
	// Limit field layout and reset values
	// ------------------------------------------------------------
	localparam int IOV_EXP_MSB = 15; // Exponent top bit
	localparam int IOV_EXP_LSB = 11; // Exponent low bit
	localparam int IOV_MAN_MSB = 10; // Mantissa top bit
	localparam logic [4:0] IOV_LIMIT_RST_EXP = 5'h1E; // Exponent reset, 11110b
	localparam logic [10:0] IOV_LIMIT_RST_MAN = 11'h050; // Plain default mantissa

	// ------------------------------------------------------------
	// Response field layout and reset value
	// ------------------------------------------------------------
	localparam int IOV_ACT_MSB = 7; // Action field top bit
	localparam int IOV_ACT_LSB = 6; // Action field low bit
	localparam int IOV_RTY_MSB = 5; // Retry field top bit
	localparam int IOV_RTY_LSB = 3; // Retry field low bit
	localparam int IOV_DLY_MSB = 2; // Delay field top bit
	localparam logic [7:0] IOV_RESP_RST = 8'h80; // Plain default: immediate, latch off

	// Action encodings
	localparam logic [1:0] IOV_ACT_IGNORE = 2'h0;
	localparam logic [1:0] IOV_ACT_DELAYED = 2'h1;
	localparam logic [1:0] IOV_ACT_IMMEDIATE = 2'h2;
	localparam logic [1:0] IOV_ACT_INVALID = 2'h3;

	// Retry encodings
	localparam logic [2:0] IOV_RTY_LATCH = 3'h0;
	localparam logic [2:0] IOV_RTY_FOREVER = 3'h7;

	// ------------------------------------------------------------
	// Shutdown delays in switching cycles
	// ------------------------------------------------------------
	localparam logic [2:0] IOV_SHDN_SHORT = 3'h1; // Delay field 0..1
	localparam logic [2:0] IOV_SHDN_MID = 3'h3; // Delay field 2..4
	localparam logic [2:0] IOV_SHDN_LONG = 3'h7; // Delay field 5..7
	localparam logic [2:0] IOV_DLY_MID_LO = 3'h2; // First field value of middle band
	localparam logic [2:0] IOV_DLY_LONG_LO = 3'h5; // First field value of long band

	// ------------------------------------------------------------
	// Voltage scale: measured input in 1/256 V steps
	// ------------------------------------------------------------
	localparam int IOV_FRAC_BITS = 8; // Fraction bits of the fixed-point volt
	localparam logic signed [31:0] IOV_LIM_MIN = 32'sh0000_0400; // 4 V
	localparam logic signed [31:0] IOV_LIM_MAX = 32'sh0000_1400; // 20 V
	localparam int IOV_STEP_SHIFT = 6; // 0.25 V is 64 fixed-point steps
	localparam logic signed [31:0] IOV_STEP_HALF = 32'sh0000_0020; // Rounding half step
	localparam logic signed [31:0] IOV_Q_MIN = 32'sh0000_0010; // 4 V in quarter volts
	localparam logic signed [31:0] IOV_Q_MAX = 32'sh0000_0050; // 20 V in quarter volts
	localparam logic [4:0] IOV_Q_EXP = 5'h1E; // Exponent of a quarter volt

	// Linear word to fixed-point volts
	function automatic logic signed [31:0] iov_lin_to_fix(input logic [15:0] lin);
		logic signed [31:0] m;
		logic signed [5:0] e;
		m = 32'(signed'(lin[IOV_MAN_MSB:0]));
		e = 6'(signed'(lin[IOV_EXP_MSB:IOV_EXP_LSB])) + 6'sd8;
		if (e >= 0) begin
			iov_lin_to_fix = m <<< e;
		end else begin
			iov_lin_to_fix = m >>> (-e);
		end
	endfunction

	// Linear word to the nearest supported quarter-volt setting
	function automatic logic [15:0] iov_nearest(input logic [15:0] lin);
		logic signed [31:0] q;
		q = (iov_lin_to_fix(lin) + IOV_STEP_HALF) >>> IOV_STEP_SHIFT;
		if (q < IOV_Q_MIN) begin
			q = IOV_Q_MIN;
		end else if (q > IOV_Q_MAX) begin
			q = IOV_Q_MAX;
		end
		iov_nearest = {IOV_Q_EXP, q[IOV_MAN_MSB:0]};
	endfunction

endpackage

// ==== hw/iov_tmr_if.sv ====
// Carrier between the fault controller and its restart wait timer
`timescale 1ns/1ps
interface iov_tmr_if;
	logic start; // Pulse: begin a restart wait
	logic pwm_tick; // Pulse: one switching cycle
	logic [2:0] mult; // Rise-time multiple
	logic [15:0] rise_ticks; // Soft-start rise time in switching cycles
	logic done; // Pulse: wait elapsed
	logic busy; // Level: wait running

	modport ctl (output start, pwm_tick, mult, rise_ticks, input done, busy);
	modport tmr (input start, pwm_tick, mult, rise_ticks, output done, busy);
endinterface

// ==== hw/iov_restart_timer.sv ====
// Restart wait timer counting switching cycles
`timescale 1ns/1ps
module iov_restart_timer
	import iov_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rst_n,
	iov_tmr_if.tmr tif
);

	// ------------------------------------------------------------
	// Count state
	// ------------------------------------------------------------
	logic [18:0] target_r; // Cycles to wait
	logic [18:0] count_r; // Cycles waited so far
	logic busy_r; // Wait in progress
	logic done_r; // Wait-elapsed pulse

	wire logic [18:0] target_nxt = 19'(tif.mult) * 19'(tif.rise_ticks);
	wire logic [18:0] count_inc = count_r + 19'h0_0001;
	wire logic at_end = tif.pwm_tick && (count_inc >= target_r);

	assign tif.busy = busy_r;
	assign tif.done = done_r;

	// Load on start, count switching cycles, pulse done at the end
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			target_r <= 19'h0_0000;
			count_r <= 19'h0_0000;
			busy_r <= 1'b0;
			done_r <= 1'b0;
		end else begin
			done_r <= 1'b0;
			if (tif.start) begin
				target_r <= target_nxt;
				count_r <= 19'h0_0000;
				busy_r <= 1'b1;
			end else if (busy_r && tif.pwm_tick) begin
				count_r <= count_inc;
				busy_r <= !at_end;
				done_r <= at_end;
			end
		end
	end

endmodule

// ==== hw/iov_fault_ctl.sv ====
// Input overvoltage limit, response setting and fault reaction
// What this block does
// - Limit holds linear exponent and mantissa
// - Fault when input voltage exceeds limit
// - Accept limits 4 V to 20 V only
// - Out-of-range limit write flags invalid data
// - Restore reloads nearest supported limit value
// - Response is one byte, byte access
// - Fault sets three status bits, alerts host
// - Action 00 ignores the fault
// - Action 01 shuts down after delay
// - Action 10 shuts down immediately
// - Action 11 and bad encodings rejected
// - Retry 0 latches off
// - Retry 1-6 waits, retries, then latches
// - Attempts during overvoltage still count
// - Retry 7 retries without limit
// - Delay 0-1: one cycle, one rise
// - Delay 2-4: three cycles, field rises
// - Delay 5-7: seven cycles, field rises
`timescale 1ns/1ps
module iov_fault_ctl
	import iov_pkg::*;
#(
	parameter logic [10:0] LIMIT_RST_MAN = IOV_LIMIT_RST_MAN,
	parameter logic [7:0] RESP_RST = IOV_RESP_RST
)
(
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic [15:0] power_input_voltage,
	input wire logic pwm_tick,
	input wire logic [15:0] soft_start_rise_ticks,
	input wire logic startup_done,
	input wire logic output_on_cmd,
	input wire logic nvm_restore,
	input wire logic cmd_wr,
	input wire logic cmd_rd,
	input wire logic cmd_word,
	input wire logic [7:0] cmd_code,
	input wire logic [15:0] cmd_wdata,
	input wire logic clear_faults,
	output logic [15:0] rd_data,
	output logic rd_valid,
	output logic switching_enable,
	output logic input_overvoltage_event,
	output logic status_none_of_above,
	output logic status_word_input,
	output logic input_overvoltage_status_flag,
	output logic invalid_data_flag,
	output logic host_alert,
	output logic latched_off,
	output logic [2:0] retry_count
);

	// ------------------------------------------------------------
	// Types and storage
	// ------------------------------------------------------------
	typedef enum logic [1:0] {IOV_RUN, IOV_DELAY, IOV_WAIT, IOV_LATCH} iov_state_t;

	iov_state_t state_r; // Reaction state
	iov_state_t state_nxt; // Next reaction state
	logic [15:0] input_overvoltage_limit_r; // Limit word
	logic [7:0] input_overvoltage_response_r; // Response byte
	logic [2:0] dly_count_r; // Consecutive faulted cycles in delay
	logic [2:0] dly_count_nxt; // Next delay count
	logic [2:0] attempts_r; // Restart attempts made
	logic [2:0] attempts_nxt; // Next attempt count
	logic nota_r; // Status byte none-of-the-above
	logic word_in_r; // Status word input bit
	logic ov_flag_r; // Input status overvoltage bit
	logic inv_r; // Invalid data bit
	logic event_r; // One-cycle fault event
	logic [15:0] rd_data_r; // Read data
	logic rd_valid_r; // Read data valid
	logic tmr_start; // Begin a restart wait

	iov_tmr_if tif ();

	// ------------------------------------------------------------
	// Response field decode
	// ------------------------------------------------------------
	wire logic [1:0] action_field = input_overvoltage_response_r[IOV_ACT_MSB:IOV_ACT_LSB];
	wire logic [2:0] retry_field = input_overvoltage_response_r[IOV_RTY_MSB:IOV_RTY_LSB];
	wire logic [2:0] delay_field = input_overvoltage_response_r[IOV_DLY_MSB:0];

	// Shutdown delay in switching cycles from the delay field
	function automatic logic [2:0] shdn_cycles(input logic [2:0] dly);
		if (dly >= IOV_DLY_LONG_LO) begin
			shdn_cycles = IOV_SHDN_LONG;
		end else if (dly >= IOV_DLY_MID_LO) begin
			shdn_cycles = IOV_SHDN_MID;
		end else begin
			shdn_cycles = IOV_SHDN_SHORT;
		end
	endfunction

	// Restart wait multiple of the rise time; 0 and 1 both mean one rise time
	function automatic logic [2:0] wait_mult(input logic [2:0] dly);
		wait_mult = (dly < IOV_DLY_MID_LO) ? 3'h1 : dly;
	endfunction

	wire logic [2:0] shdn_len = shdn_cycles(delay_field);

	// ------------------------------------------------------------
	// Overvoltage comparison and write checks
	// ------------------------------------------------------------
	wire logic signed [31:0] limit_fix = iov_lin_to_fix(input_overvoltage_limit_r);
	wire logic signed [31:0] vin_fix = 32'(signed'({16'h0000, power_input_voltage}));
	wire logic over_limit = vin_fix > limit_fix;
	wire logic fault_tick = pwm_tick && over_limit;

	wire logic signed [31:0] wr_fix = iov_lin_to_fix(cmd_wdata);
	wire logic wr_limit = cmd_wr && (cmd_code == IOV_CMD_LIMIT);
	wire logic wr_resp = cmd_wr && (cmd_code == IOV_CMD_RESP);
	wire logic limit_ok = cmd_word && (wr_fix >= IOV_LIM_MIN) && (wr_fix <= IOV_LIM_MAX);
	wire logic resp_ok = !cmd_word &&
		(cmd_wdata[IOV_ACT_MSB:IOV_ACT_LSB] != IOV_ACT_INVALID);
	wire logic wr_bad = (wr_limit && !limit_ok) || (wr_resp && !resp_ok);

	// ------------------------------------------------------------
	// Limit register: reset, restore and checked writes
	// ------------------------------------------------------------
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			input_overvoltage_limit_r <= {IOV_LIMIT_RST_EXP, LIMIT_RST_MAN};
		end else if (nvm_restore) begin
			input_overvoltage_limit_r <= iov_nearest(input_overvoltage_limit_r);
		end else if (wr_limit && limit_ok) begin
			input_overvoltage_limit_r <= cmd_wdata;
		end
	end

	// ------------------------------------------------------------
	// Response register: only valid byte writes land
	// ------------------------------------------------------------
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			input_overvoltage_response_r <= RESP_RST;
		end else if (wr_resp && resp_ok) begin
			input_overvoltage_response_r <= cmd_wdata[7:0];
		end
	end

	// ------------------------------------------------------------
	// Read port: data registered one cycle after the strobe
	// ------------------------------------------------------------
	wire logic [15:0] rd_mux = (cmd_code == IOV_CMD_LIMIT) ? input_overvoltage_limit_r :
		(cmd_code == IOV_CMD_RESP) ? {8'h00, input_overvoltage_response_r} : 16'h0000;

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			rd_data_r <= 16'h0000;
			rd_valid_r <= 1'b0;
		end else begin
			rd_valid_r <= cmd_rd;
			if (cmd_rd) begin
				rd_data_r <= rd_mux;
			end
		end
	end

	// ------------------------------------------------------------
	// Status bits: hardware set wins over a clear in the same cycle
	// ------------------------------------------------------------
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			nota_r <= 1'b0;
			word_in_r <= 1'b0;
			ov_flag_r <= 1'b0;
			inv_r <= 1'b0;
			event_r <= 1'b0;
		end else begin
			event_r <= fault_tick;
			// Fault sets all three status bits
			nota_r <= fault_tick || (nota_r && !clear_faults);
			word_in_r <= fault_tick || (word_in_r && !clear_faults);
			ov_flag_r <= fault_tick || (ov_flag_r && !clear_faults);
			// Rejected writes set the invalid data bit
			inv_r <= wr_bad || (inv_r && !clear_faults);
		end
	end

	// ------------------------------------------------------------
	// Reaction state machine
	// ------------------------------------------------------------
	wire logic retry_left = (retry_field == IOV_RTY_FOREVER) ||
		(attempts_r < retry_field);
	wire logic [2:0] dly_inc = dly_count_r + 3'h1;

	always_comb begin
		state_nxt = state_r;
		dly_count_nxt = dly_count_r;
		attempts_nxt = attempts_r;
		tmr_start = 1'b0;
		case (state_r)
			IOV_RUN: begin
				// Switching; every faulted cycle is judged by the action field
				if (!output_on_cmd) begin
					attempts_nxt = 3'h0;
				end else if (fault_tick) begin
					if (action_field == IOV_ACT_DELAYED) begin
						state_nxt = IOV_DELAY;
						dly_count_nxt = 3'h0;
					end else if (action_field == IOV_ACT_IMMEDIATE) begin
						// Shutdown now, then retry policy
						if (retry_field != IOV_RTY_LATCH && retry_left) begin
							state_nxt = IOV_WAIT;
							tmr_start = 1'b1;
						end else begin
							state_nxt = IOV_LATCH;
						end
					end
					// Action 00 keeps running
				end else if (startup_done) begin
					attempts_nxt = 3'h0; // Successful startup ends the retry run
				end
			end
			IOV_DELAY: begin
				// Count consecutive faulted cycles, restart count when clear
				if (!output_on_cmd) begin
					state_nxt = IOV_RUN;
					attempts_nxt = 3'h0;
				end else if (pwm_tick && !over_limit) begin
					state_nxt = IOV_RUN;
				end else if (fault_tick) begin
					dly_count_nxt = dly_inc;
					if (dly_inc >= shdn_len) begin
						// Delay spent and fault persists
						if (retry_field != IOV_RTY_LATCH && retry_left) begin
							state_nxt = IOV_WAIT;
							tmr_start = 1'b1;
						end else begin
							state_nxt = IOV_LATCH;
						end
					end
				end
			end
			IOV_WAIT: begin
				// Off for one restart wait, then attempt a restart
				if (!output_on_cmd) begin
					state_nxt = IOV_RUN;
					attempts_nxt = 3'h0;
				end else if (tif.done) begin
					state_nxt = IOV_RUN;
					// Counted even when the input is still over the limit
					if (attempts_r != IOV_RTY_FOREVER) begin
						attempts_nxt = attempts_r + 3'h1;
					end
				end
			end
			IOV_LATCH: begin
				// Stay off until commanded off
				if (!output_on_cmd) begin
					state_nxt = IOV_RUN;
					attempts_nxt = 3'h0;
				end
			end
			default: begin
				state_nxt = IOV_LATCH;
			end
		endcase
	end

	// State, delay count and attempt count registers
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_r <= IOV_RUN;
			dly_count_r <= 3'h0;
			attempts_r <= 3'h0;
		end else begin
			state_r <= state_nxt;
			dly_count_r <= dly_count_nxt;
			attempts_r <= attempts_nxt;
		end
	end

	// ------------------------------------------------------------
	// Restart wait timer
	// ------------------------------------------------------------
	assign tif.start = tmr_start;
	assign tif.pwm_tick = pwm_tick;
	assign tif.mult = wait_mult(delay_field);
	assign tif.rise_ticks = soft_start_rise_ticks;

	iov_restart_timer u_timer (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.tif(tif.tmr)
	);

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign switching_enable = output_on_cmd &&
		((state_r == IOV_RUN) || (state_r == IOV_DELAY));
	assign input_overvoltage_event = event_r;
	assign status_none_of_above = nota_r;
	assign status_word_input = word_in_r;
	assign input_overvoltage_status_flag = ov_flag_r;
	assign invalid_data_flag = inv_r;
	assign host_alert = nota_r || inv_r;
	assign latched_off = (state_r == IOV_LATCH);
	assign retry_count = attempts_r;
	assign rd_data = rd_data_r;
	assign rd_valid = rd_valid_r;

endmodule

// ==== dv/iov_fault_ctl_asserts.sv ====
// Port checker for the input overvoltage fault block
`timescale 1ns/1ps
module iov_fault_ctl_asserts
	import iov_pkg::*;
(
	input logic ref_clk,
	input logic rst_n,
	input logic pwm_tick,
	input logic output_on_cmd,
	input logic cmd_wr,
	input logic cmd_rd,
	input logic cmd_word,
	input logic [7:0] cmd_code,
	input logic [15:0] cmd_wdata,
	input logic clear_faults,
	input logic rd_valid,
	input logic switching_enable,
	input logic input_overvoltage_event,
	input logic status_none_of_above,
	input logic status_word_input,
	input logic input_overvoltage_status_flag,
	input logic invalid_data_flag,
	input logic host_alert,
	input logic latched_off
);
	// Decoded limit and response writes
	wire logic wr_lim = cmd_wr && cmd_code == IOV_CMD_LIMIT;
	wire logic wr_rsp = cmd_wr && cmd_code == IOV_CMD_RESP && !cmd_word;
	wire logic [10:0] man = cmd_wdata[10:0];
	// Quarter-volt word outside 4 V to 20 V, negative mantissas included
	wire logic lim_bad = cmd_wdata[15:11] == 5'h1E && (man < 11'h010 || man > 11'h050);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	a_read_answer: assert property (cmd_rd |=> rd_valid)
		else $error("read not answered");
	a_read_no_stray: assert property (!cmd_rd |=> !rd_valid)
		else $error("read answer without request");
	a_event_on_tick: assert property (input_overvoltage_event |-> $past(pwm_tick))
		else $error("fault event outside a switching cycle");
	a_event_flags: assert property (input_overvoltage_event |->
		status_none_of_above && status_word_input && input_overvoltage_status_flag)
		else $error("fault event without status bits");
	a_alert_sum: assert property (host_alert == (status_none_of_above || invalid_data_flag))
		else $error("alert does not follow status");
	a_flag_sticky: assert property (input_overvoltage_status_flag && !clear_faults
		|=> input_overvoltage_status_flag)
		else $error("status bit dropped without clear");
	a_limit_range: assert property (wr_lim && cmd_word && lim_bad |=> invalid_data_flag)
		else $error("out of range limit not flagged");
	a_limit_byte: assert property (wr_lim && !cmd_word |=> invalid_data_flag)
		else $error("byte write to limit not flagged");
	a_action_bad: assert property (wr_rsp && cmd_wdata[7:6] == IOV_ACT_INVALID
		|=> invalid_data_flag)
		else $error("invalid action not flagged");
	a_latch_dark: assert property (latched_off |-> !switching_enable)
		else $error("switching while latched off");
	a_stop_cause: assert property ($fell(switching_enable) && output_on_cmd && $past(output_on_cmd)
		|-> $past(pwm_tick))
		else $error("shutdown outside a switching cycle");
endmodule
bind iov_fault_ctl iov_fault_ctl_asserts u_chk (.ref_clk(ref_clk), .rst_n(rst_n),
	.pwm_tick(pwm_tick), .output_on_cmd(output_on_cmd), .cmd_wr(cmd_wr), .cmd_rd(cmd_rd),
	.cmd_word(cmd_word), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .clear_faults(clear_faults),
	.rd_valid(rd_valid), .switching_enable(switching_enable),
	.input_overvoltage_event(input_overvoltage_event), .status_none_of_above(status_none_of_above),
	.status_word_input(status_word_input),
	.input_overvoltage_status_flag(input_overvoltage_status_flag),
	.invalid_data_flag(invalid_data_flag), .host_alert(host_alert), .latched_off(latched_off));

// ==== dv/iov_host_model.sv ====
// Host model issuing command writes and reads
`timescale 1ns/1ps
module iov_host_model (
	input logic ref_clk,
	output logic cmd_wr,
	output logic cmd_rd,
	output logic cmd_word,
	output logic [7:0] cmd_code,
	output logic [15:0] cmd_wdata,
	input logic [15:0] rd_data,
	input logic rd_valid
);
	// Idle bus at time zero
	initial begin
		{cmd_wr, cmd_rd, cmd_word, cmd_code, cmd_wdata} = '0;
	end
	// One-cycle write strobe; released buses show the inverse of the last value
	task automatic wr(input logic [7:0] code, input logic word, input logic [15:0] data);
		@(posedge ref_clk);
		{cmd_wr, cmd_word, cmd_code, cmd_wdata} <= {1'b1, word, code, data};
		@(posedge ref_clk);
		{cmd_wr, cmd_code, cmd_wdata} <= {1'b0, ~code, ~data};
	endtask
	// One-cycle read strobe; answer taken one edge after the request edge
	task automatic rd(input logic [7:0] code, input logic word, output logic [15:0] d,
		output logic ok);
		@(posedge ref_clk);
		{cmd_rd, cmd_word, cmd_code} <= {1'b1, word, code};
		@(posedge ref_clk);
		{cmd_rd, cmd_code} <= {1'b0, ~code};
		@(posedge ref_clk);
		ok = rd_valid;
		d = rd_data;
	endtask
endmodule

// ==== dv/test_input_overvoltage_fault_response.sv ====
// Self-checking bench for the input overvoltage fault block
`timescale 1ns/1ps
module test_input_overvoltage_fault_response;
	import iov_pkg::*;
	logic ref_clk = 1'b0;
	logic rst_n = 1'b0;
	logic [15:0] vin = 16'h0300; // Measured input, 1/256 V steps; 3 V sits below any legal limit
	logic pwm_tick = 1'b0;
	logic [1:0] ph = 2'h0; // Switching cycle phase
	logic [15:0] rise = 16'h0002; // Soft-start rise in switching cycles
	logic on = 1'b1;
	logic restore = 1'b0;
	logic clr = 1'b0;
	logic sdone = 1'b0; // Soft-start success pulse
	wire logic cmd_wr, cmd_rd, cmd_word, rd_valid, sw_en, ev, none_ab, word_in, ov_flag;
	wire logic bad_flag, alert, latched_off;
	wire logic [7:0] cmd_code;
	wire logic [15:0] cmd_wdata, rd_data;
	wire logic [2:0] retry_count;
	int error_cnt = 0;
	int n_tests = 0;
	int n_ev = 0; // Fault events seen
	int seed = 32'h7da4_d59c;
	logic [15:0] lim_tab [6] = '{16'hF010, 16'hF050, 16'hF00F, 16'hF051, 16'hF7FF, 16'hF030};
	logic [7:0] run_tab [6] = '{8'h80, 8'h91, 8'h4A, 8'h44, 8'h6D, 8'hBF};
	iov_fault_ctl DUT (.ref_clk(ref_clk), .rst_n(rst_n), .power_input_voltage(vin),
		.pwm_tick(pwm_tick), .soft_start_rise_ticks(rise), .startup_done(sdone),
		.output_on_cmd(on), .nvm_restore(restore), .cmd_wr(cmd_wr), .cmd_rd(cmd_rd),
		.cmd_word(cmd_word), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .clear_faults(clr),
		.rd_data(rd_data), .rd_valid(rd_valid), .switching_enable(sw_en),
		.input_overvoltage_event(ev), .status_none_of_above(none_ab),
		.status_word_input(word_in), .input_overvoltage_status_flag(ov_flag),
		.invalid_data_flag(bad_flag), .host_alert(alert), .latched_off(latched_off),
		.retry_count(retry_count));
	iov_host_model host (.ref_clk(ref_clk), .cmd_wr(cmd_wr), .cmd_rd(cmd_rd),
		.cmd_word(cmd_word), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .rd_data(rd_data),
		.rd_valid(rd_valid));
	// Clock and a switching-cycle pulse every fourth clock
	always #25 ref_clk = ~ref_clk;
	always @(posedge ref_clk) begin
		ph <= ph + 2'h1;
		pwm_tick <= (ph == 2'h3);
		if (ev === 1'b1) n_ev <= n_ev + 1;
	end
	// Compare and count
	task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
		n_tests++;
		if (seen !== exp) begin
			error_cnt++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// Faulted switching cycles before shutdown
	function automatic int stop_ticks(input logic [7:0] r);
		if (r[7:6] == 2'b10) return 1;
		return (r[2:0] < 2) ? 2 : (r[2:0] < 5) ? 4 : 8;
	endfunction
	// Restart wait in switching cycles
	function automatic int wait_ticks(input logic [7:0] r, input logic [15:0] rt);
		return ((r[2:0] < 2) ? 1 : int'(r[2:0])) * int'(rt);
	endfunction
	// Good limit word: quarter volts from 4 V to 20 V
	function automatic logic lim_ok(input logic [15:0] w, input logic word);
		return word && w[15:11] == 5'h1E && w[10:0] >= 11'h010 && w[10:0] <= 11'h050;
	endfunction
	// Count switching cycles while the output stays at one level
	task automatic count_while(input logic lvl, output int k);
		int g;
		k = 0;
		g = 0;
		do begin
			@(posedge ref_clk);
			if (pwm_tick) k++;
			#1;
			g++;
		end while (sw_en === lvl && g < 3000);
		if (g >= 3000) chk("wait bound", 16'h0001, 16'h0000);
	endtask
	// Persistent fault under one response setting
	task automatic fault_run(input logic [7:0] r);
		int n, k;
		n = (r[5:3] == 3'h7) ? 8 : int'(r[5:3]);
		host.wr(IOV_CMD_RESP, 1'b0, {8'h00, r});
		vin <= 16'h0900;
		for (int i = 0; i <= n; i++) begin
			count_while(1'b1, k);
			chk("stop ticks", 16'(k), 16'(stop_ticks(r)));
			if (i < n) count_while(1'b0, k);
			if (i < n) chk("restart wait", 16'(k), 16'(wait_ticks(r, rise)));
		end
		repeat (2) @(posedge ref_clk);
		chk("latched", 16'(latched_off), 16'(r[5:3] != 3'h7));
		chk("attempts", 16'(retry_count), 16'((n > 7) ? 7 : n));
		vin <= 16'h0700;
		on <= 1'b0;
		@(posedge ref_clk);
		on <= 1'b1;
		rise <= 16'(1 + {$random(seed)} % 3);
	endtask
	// Verdict
	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	// Watchdog
	initial begin
		repeat (60000) @(posedge ref_clk);
		error_cnt++;
		tally_and_finish();
	end
	// Main sequence
	initial begin
		logic [15:0] d, cur, w;
		logic ok;
		int e0;
		repeat (6) @(posedge ref_clk);
		rst_n <= 1'b1;
		host.rd(IOV_CMD_LIMIT, 1'b1, d, ok);
		chk("limit reset", d, {5'h1E, IOV_LIMIT_RST_MAN});
		chk("read answer", 16'(ok), 16'h0001);
		host.rd(IOV_CMD_RESP, 1'b0, d, ok);
		chk("response reset", d, {8'h00, IOV_RESP_RST});
		cur = {5'h1E, IOV_LIMIT_RST_MAN};
		// Range edges, out-of-range words, a byte write, then random good words
		for (int i = 0; i < 10; i++) begin
			w = (i < 6) ? lim_tab[i] : {5'h1E, 11'(16 + {$random(seed)} % 65)};
			clr <= 1'b1;
			@(posedge ref_clk);
			clr <= 1'b0;
			host.wr(IOV_CMD_LIMIT, i != 5, w);
			#1;
			chk("limit refused", 16'(bad_flag), 16'(!lim_ok(w, i != 5)));
			if (lim_ok(w, i != 5)) cur = w;
			host.rd(IOV_CMD_LIMIT, 1'b1, d, ok);
			chk("limit value", d, cur);
		end
		// Every action code; the invalid one is not stored
		for (int a = 0; a < 4; a++) begin
			host.wr(IOV_CMD_RESP, 1'b0, {8'h00, 2'(a), 6'h0A});
			if (a < 3) cur = {8'h00, 2'(a), 6'h0A};
			host.rd(IOV_CMD_RESP, 1'b0, d, ok);
			chk("response value", d, cur);
		end
		chk("invalid flag", 16'(bad_flag), 16'h0001);
		// Restore snaps 10.125 V to 10.25 V
		host.wr(IOV_CMD_LIMIT, 1'b1, 16'hE851);
		restore <= 1'b1;
		@(posedge ref_clk);
		restore <= 1'b0;
		host.rd(IOV_CMD_LIMIT, 1'b1, d, ok);
		chk("restored limit", d, 16'hF029);
		// 8 V limit: equal voltage is no fault, one step above is
		host.wr(IOV_CMD_LIMIT, 1'b1, 16'hF020);
		host.wr(IOV_CMD_RESP, 1'b0, 16'h0000);
		vin <= 16'h0800;
		clr <= 1'b1;
		@(posedge ref_clk);
		clr <= 1'b0;
		e0 = n_ev;
		repeat (12) @(posedge ref_clk);
		chk("no fault at limit", 16'(n_ev - e0), 16'h0000);
		vin <= 16'h0801;
		repeat (12) @(posedge ref_clk);
		#1;
		chk("fault above limit", 16'(n_ev > e0), 16'h0001);
		chk("status bits", {13'h0000, none_ab, word_in, ov_flag}, 16'h0007);
		chk("alert", 16'(alert), 16'h0001);
		chk("ignored fault", 16'(sw_en), 16'h0001);
		@(posedge ref_clk);
		vin <= 16'h0700;
		for (int i = 0; i < 6; i++) fault_run(run_tab[i]);
		// A good startup ends a retry run and clears the attempt count
		host.wr(IOV_CMD_RESP, 1'b0, 16'h0091);
		vin <= 16'h0900;
		count_while(1'b1, e0);
		count_while(1'b0, e0);
		chk("attempts before start", 16'(retry_count), 16'h0001);
		@(posedge ref_clk);
		vin <= 16'h0700;
		sdone <= 1'b1;
		@(posedge ref_clk);
		sdone <= 1'b0;
		#1;
		chk("attempts after start", 16'(retry_count), 16'h0000);
		tally_and_finish();
	end
endmodule
